//--- include/srh_map.svh
// Timing constants and pin widths for the static memory host controller
`ifndef SRH_MAP_SVH
`define SRH_MAP_SVH

`define SRH_ADDR_W        13
`define SRH_DATA_W        9
`define SRH_CLK_PERIOD_NS 100
// Fastest-grade figures, in ns
`define SRH_T_RC_NS       12
`define SRH_T_AA_NS       12
`define SRH_T_OH_NS       4
`define SRH_T_WP_NS       10
`define SRH_T_AW_NS       12
`define SRH_T_DW_NS       7
`define SRH_T_GHQZ_NS     6
// Least times and access time both round up; SRH_FLOOR_CYC rounds down, floor one cycle
`define SRH_CEIL_CYC(t)  (((t) + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_FLOOR_CYC(t) (((t) / `SRH_CLK_PERIOD_NS) < 1 ? 1 : \
                          ((t) / `SRH_CLK_PERIOD_NS))
`define SRH_WP_CYC       `SRH_CEIL_CYC(`SRH_T_WP_NS)
`define SRH_AW_CYC       `SRH_CEIL_CYC(`SRH_T_AW_NS)
`define SRH_RC_CYC       `SRH_CEIL_CYC(`SRH_T_RC_NS)
`define SRH_HIZ_CYC      `SRH_CEIL_CYC(`SRH_T_GHQZ_NS)
// Data may settle no later than access time; sample after a whole wait
`define SRH_ACC_CYC      `SRH_CEIL_CYC(`SRH_T_AA_NS)

`endif

//--- include/srh_pkg.sv
// Types for the static memory host controller
package srh_pkg;
  typedef enum logic [2:0]
  {
    SRH_IDLE,
    SRH_RD_WAIT,
    SRH_RD_DONE,
    SRH_WR_STROBE,
    SRH_WR_END,
    SRH_TURN
  } srh_state_t;
endpackage

//--- include/srh_tmr_if.sv
// Carrier between the controller and its cycle timer
`timescale 1ns/1ns
interface srh_tmr_if;
  logic       load;
  logic [3:0] count;
  logic       done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

//--- rtl/srh_ctrl.sv
// Host controller that drives an 8K x 9 asynchronous static memory
// Behaviour
// - Controller keeps write strobe high during every read.
// - Read cycle at least 12 ns; data valid 12 ns after address.
// - Strobe write: address 10 ns, strobe low 10 ns, data 6 ns.
// - Address setup, recovery and data hold may be 0 ns.
// - Select write: select 10 ns, data 7 ns, address 12 ns.
`timescale 1ns/1ns
`include "srh_map.svh"
module srh_ctrl
#(
  parameter int ADDR_W = `SRH_ADDR_W,
  parameter int DATA_W = `SRH_DATA_W
)
(
  input  wire logic              core_clk,            // System clock
  input  wire logic              rst_n,               // Sync reset, low
  input  wire logic              req_valid,           // Request present
  input  wire logic              req_write,           // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] req_addr,            // Word address
  input  wire logic [DATA_W-1:0] req_wdata,           // Write data
  output logic                   req_ready,           // Request taken
  output logic                   rsp_valid,           // Read data pulse
  output logic      [DATA_W-1:0] rsp_rdata,           // Read data
  output logic      [ADDR_W-1:0] word_address_bus,    // Memory address
  output logic                   select_active_low,   // Low select pin
  output logic                   select_active_high,  // High select pin
  output logic                   output_gate_n,       // Output gate pin
  output logic                   write_strobe_n,      // Write strobe pin
  input  wire logic [DATA_W-1:0] shared_data_bus_in,  // Bus level seen
  output logic      [DATA_W-1:0] shared_data_bus_out, // Bus drive value
  output logic                   shared_data_bus_oe   // High while driving
);
  typedef struct packed
  {
    srh_pkg::srh_state_t state;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic                drive;
    logic                sel;
    logic                gate_n;
    logic                strobe_n;
    logic                rsp;
    logic [DATA_W-1:0]   rdata;
  } srh_st_t;

  srh_st_t    st_reg;
  srh_st_t    st_next;
  srh_tmr_if  tmr ();

  srh_timer u_timer
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tmr      (tmr)
  );

  always_comb
  begin
    st_next    = st_reg;
    st_next.rsp = 1'b0;
    tmr.load   = 1'b0;
    tmr.count  = 4'h0;
    case (st_reg.state)
      srh_pkg::SRH_IDLE:
      begin
        if (req_valid && tmr.done)
        begin
          // Address applied with zero setup before select and strobe
          st_next.addr = req_addr;
          st_next.sel  = 1'b1;
          if (req_write)
          begin
            st_next.wdata    = req_wdata;
            st_next.drive    = 1'b1;
            st_next.gate_n   = 1'b1;
            st_next.strobe_n = 1'b0;
            tmr.load         = 1'b1;
            // Longest of pulse, address-valid and data-valid minima
            tmr.count        = 4'(`SRH_AW_CYC);
            st_next.state    = srh_pkg::SRH_WR_STROBE;
          end
          else
          begin
            st_next.strobe_n = 1'b1;
            st_next.gate_n   = 1'b0;
            tmr.load         = 1'b1;
            tmr.count        = 4'(`SRH_ACC_CYC);
            st_next.state    = srh_pkg::SRH_RD_WAIT;
          end
        end
      end
      srh_pkg::SRH_RD_WAIT:
      begin
        if (tmr.done)
        begin
          // Sampled before address or gate move, inside the hold window
          st_next.rdata = shared_data_bus_in;
          st_next.rsp   = 1'b1;
          st_next.state = srh_pkg::SRH_RD_DONE;
        end
      end
      srh_pkg::SRH_RD_DONE:
      begin
        st_next.gate_n = 1'b1;
        st_next.sel    = 1'b0;
        tmr.load       = 1'b1;
        tmr.count      = 4'(`SRH_HIZ_CYC);
        st_next.state  = srh_pkg::SRH_TURN;
      end
      srh_pkg::SRH_WR_STROBE:
      begin
        if (tmr.done)
        begin
          // Strobe and select rise together; data stays a cycle more
          st_next.strobe_n = 1'b1;
          st_next.sel      = 1'b0;
          st_next.state    = srh_pkg::SRH_WR_END;
        end
      end
      srh_pkg::SRH_WR_END:
      begin
        st_next.drive = 1'b0;
        tmr.load      = 1'b1;
        tmr.count     = 4'(`SRH_RC_CYC);
        st_next.state = srh_pkg::SRH_TURN;
      end
      srh_pkg::SRH_TURN:
      begin
        if (tmr.done)
          st_next.state = srh_pkg::SRH_IDLE;
      end
      default:
        st_next.state = srh_pkg::SRH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_reg          <= '0;
      st_reg.state    <= srh_pkg::SRH_IDLE;
      st_reg.gate_n   <= 1'b1;
      st_reg.strobe_n <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign req_ready           = (st_reg.state == srh_pkg::SRH_IDLE) &&
                               tmr.done;
  assign rsp_valid           = st_reg.rsp;
  assign rsp_rdata           = st_reg.rdata;
  assign word_address_bus    = st_reg.addr;
  assign select_active_low   = !st_reg.sel;
  assign select_active_high  = st_reg.sel;
  assign output_gate_n       = st_reg.gate_n;
  assign write_strobe_n      = st_reg.strobe_n;
  assign shared_data_bus_out = st_reg.wdata;
  assign shared_data_bus_oe  = st_reg.drive;

  // Never drive the bus while the memory's output gate is open
  chk_bus_no_fight: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(shared_data_bus_oe && !output_gate_n))
    else $error("host drives bus while memory output enabled");

  chk_read_strobe: assert property (@(posedge core_clk) disable iff (!rst_n)
    !output_gate_n |-> write_strobe_n)
    else $error("strobe low during read");

  chk_sel_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
    select_active_low == !select_active_high)
    else $error("selects disagree");

  sequence s_wr_start;
    $fell(write_strobe_n);
  endsequence

  chk_wr_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_wr_start |-> (!write_strobe_n && !select_active_low) [*2])
    else $error("write pulse too short");

  chk_wr_data_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(write_strobe_n) |-> shared_data_bus_oe &&
      $stable(shared_data_bus_out))
    else $error("data dropped before write end");

  chk_wr_sel_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(write_strobe_n) |-> $rose(select_active_low))
    else $error("select and strobe not ended together");

  chk_wr_addr_stab: assert property (@(posedge core_clk) disable iff (!rst_n)
    !write_strobe_n |=> $stable(word_address_bus))
    else $error("address moved during write");

  chk_rd_resp: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(output_gate_n) |-> ##[1:3] rsp_valid)
    else $error("read answer late");

  chk_rd_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !output_gate_n |=> $stable(word_address_bus))
    else $error("address moved during read");

  chk_desel_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
    select_active_low |-> write_strobe_n && output_gate_n)
    else $error("control active while deselected");
endmodule

//--- rtl/srh_timer.sv
// Down counter that times each phase of a memory cycle
`timescale 1ns/1ns
module srh_timer
(
  input  wire logic core_clk,  // System clock
  input  wire logic rst_n,     // Synchronous reset, active low
  srh_tmr_if.tmr    tmr        // Load and completion
);
  typedef struct packed
  {
    logic [3:0] cnt;
  } srh_tmr_st_t;

  srh_tmr_st_t st_reg;
  srh_tmr_st_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (tmr.load)
      st_next.cnt = tmr.count;
    else if (st_reg.cnt != 4'h0)
      st_next.cnt = st_reg.cnt - 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Load is not fed back here: the controller loads on done, so a term
  // in load would close a combinational loop through the controller
  assign tmr.done = (st_reg.cnt == 4'h0);
endmodule

//--- verification/srh_sram_model.sv
// Behavioural 8K x 9 static memory that answers the controller
`timescale 1ns/1ns
module srh_sram_model
(
  input  wire logic [12:0] word_address_bus,   // Word address
  input  wire logic        select_active_low,  // Low select
  input  wire logic        select_active_high, // High select
  input  wire logic        output_gate_n,      // Output gate
  input  wire logic        write_strobe_n,     // Write strobe
  input  wire logic [8:0]  bus_level,          // Resolved data bus
  input  wire logic        slow,               // Late access mode
  output logic      [8:0]  mem_q,              // Read drive value
  output wire logic        mem_oe              // High while driving
);
  logic [8:0] mem [0:8191];
  logic       sel;
  logic       rd_en;
  logic       wr_en;
  assign sel = !select_active_low && select_active_high;
  assign rd_en = sel && !output_gate_n &&
                 write_strobe_n;
  assign wr_en = sel && !write_strobe_n;
  // Turn-on waits 4 ns but turn-off is immediate, so drivers never overlap
  assign #(4, 0) mem_oe = rd_en;
  // Word lands as the write ends; pins settling one by one at the start
  // of a write must not scribble on the previous address
  always @(negedge wr_en)
    mem[word_address_bus] = bus_level;
  // Stale word held 4 ns, then garbage until the access time runs out
  always @(word_address_bus or rd_en)
  begin
    mem_q <= #4 ~mem[word_address_bus];
    mem_q <= #(slow ? 150 : 12) mem[word_address_bus];
  end
endmodule

//--- verification/test_srh_ctrl.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
`include "srh_map.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module test_srh_ctrl;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        req_valid = 0;
  logic        req_write = 0;
  logic [12:0] req_addr = 0;
  logic [8:0]  req_wdata = 0;
  logic        slow = 0;
  logic        req_ready, rsp_valid, sel_n, sel_h, gate_n, we_n, h_oe, m_oe;
  logic [8:0]  rsp_rdata, h_out, m_q, bus;
  logic [8:0]  last_bus = 9'h000;
  logic [12:0] mem_addr;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  srh_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_address_bus(mem_addr), .select_active_low(sel_n),
    .select_active_high(sel_h), .output_gate_n(gate_n),
    .write_strobe_n(we_n), .shared_data_bus_in(bus),
    .shared_data_bus_out(h_out), .shared_data_bus_oe(h_oe));
  srh_sram_model u_mem (.word_address_bus(mem_addr), .select_active_low(sel_n),
    .select_active_high(sel_h), .output_gate_n(gate_n),
    .write_strobe_n(we_n), .bus_level(bus), .slow(slow), .mem_q(m_q),
    .mem_oe(m_oe));
  // Undriven bus flips every cycle so a missed sample cannot look right
  assign bus = h_oe ? h_out : (m_oe ? m_q : ~last_bus);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    last_bus <= bus;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  always @(negedge core_clk)
    if (rst_n && ((h_oe && m_oe) || (!gate_n && !we_n)))
    begin
      bad_count++;
      $display("[ERR] %0t bus contention or strobe low in read", $time);
    end
  task automatic give_verdict();
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic do_req(input logic wr, input logic [12:0] a,
                        input logic [8:0] d, input logic [8:0] exp);
    int n;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 20);
    `CHK(req_ready, 1'b1)
    req_valid <= 1'b0;
    @(negedge core_clk);
    `CHK(req_ready, 1'b0)
    if (!wr)
    begin
      n = 0;
      while (rsp_valid !== 1'b1 && n < 10)
      begin
        @(negedge core_clk);
        n++;
      end
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_rdata, exp)
    end
    @(posedge core_clk);
  endtask
  task automatic chk_reset();
    `CHK({sel_n, sel_h, gate_n, we_n, h_oe}, 5'h16)
    `CHK(req_ready, 1'b1)
  endtask
  task automatic chk_table();
    logic [12:0] a [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
    logic [8:0]  d [4] = '{9'h1FF, 9'h000, 9'h155, 9'h0AA};
    foreach (a[i]) do_req(1'b1, a[i], d[i], 9'h000);
    foreach (a[i]) do_req(1'b0, a[i], 9'h000, d[i]);
  endtask
  task automatic chk_overwrite();
    do_req(1'b1, 13'h0AAA, 9'h0F0, 9'h000);
    do_req(1'b0, 13'h0AAA, 9'h000, 9'h0F0);
    do_req(1'b0, 13'h1555, 9'h000, 9'h0AA);
  endtask
  task automatic chk_slow();
    slow <= 1'b1;
    do_req(1'b0, 13'h1FFF, 9'h000, 9'h000);
    do_req(1'b0, 13'h0000, 9'h000, 9'h1FF);
    slow <= 1'b0;
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk_reset();
    @(posedge core_clk);
    chk_table();
    chk_overwrite();
    chk_slow();
    give_verdict();
  end
endmodule
